// ===== src/addr_map_pkg.sv
/*
  Constants, field layouts and carrier types for the logical address map
  translator. Assumes a 16-bit map entry numbered with bit 0 as its MSB.
*/
package addr_map_pkg;
    // ****************************************
    // Geometry
    // ****************************************
    localparam int MAP_COUNT  = 16;
    localparam int MAP_DEPTH  = 64;
    localparam int ENTRY_W    = 16;
    localparam int PPN_W      = 13;
    localparam int WORD_W     = 10;
    localparam int PHYS_W     = 24;
    localparam int STORE_SIZE = MAP_COUNT * MAP_DEPTH;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [15:0] MAP_BASE      = 16'h0000;
    localparam logic [15:0] EXEC_OFFSET   = 16'h1000;
    localparam logic [15:0] STATUS_OFFSET = 16'h1004;

    // Execution state register bit positions
    localparam int EXEC_DS_BIT   = 0;
    localparam int EXEC_PRIVILEGED_STATE_BIT_BIT = 1;
    localparam int EXEC_CS_BIT   = 2;
    localparam int EXEC_LS_BIT   = 3;

    // Map entry field positions (vector index, LSB = 0)
    localparam int ENT_ABSENT  = 0;
    localparam int ENT_DIRTY   = 1;
    localparam int ENT_REF     = 2;
    localparam int ENT_PPN_LSB = 3;
    localparam int ENT_ID_PMSB = 2;

    // Map numbers
    localparam logic [3:0] MAP_USER_DATA = 4'h0;
    localparam logic [3:0] MAP_SYS_DATA  = 4'h1;
    localparam logic [3:0] MAP_CODE_BASE = 4'h2;
    localparam logic [3:0] MAP_SPECIAL   = 4'hE;
    localparam logic [3:0] MAP_EXT_CACHE = 4'hF;

    // ****************************************
    // Carriers
    // ****************************************
    typedef enum logic [1:0] {REQ_WORD, REQ_BYTE_DATA, REQ_BYTE_CODE, REQ_EXTENDED} req_kind_t;

    typedef struct packed {
        logic       valid;
        req_kind_t  kind;
        logic       write;
        logic       sysSpace;
        logic       pcPageHigh;
        logic [31:0] addr;
    } xlate_req_t;

    typedef struct packed {
        logic              valid;
        logic [PHYS_W-1:0] physAddr;
        logic              pageFault;
        logic              privFault;
        logic              cacheMiss;
    } xlate_resp_t;
endpackage

// ===== src/logical_address_map_translation.sv
/*
  Logical-to-physical translator with its 16x64 map store behind APB.
  Assumes the datapath issues one request per cycle on clk_sys and that
  the APB master shares that clock and the synchronous reset.
*/
// Summary of operation
// - Word address: bits 0-5 give logical page.
// - Word address: bits 6-15 give word within page.
// - Byte address: bit 15 picks byte, 0 left, 1 right.
// - Data byte address: page field bits 0-4 only, first 32 pages.
// - Code byte address: missing page bit comes from program counter.
// - Extended address bit 0: 0 relative, 1 absolute.
// - Absolute extended mode only when privileged.
// - Extended bits 2-14 select one of 8192 segments.
// - Extended bits 15-20 page, 21-30 word, 31 byte.
// - Every extended address is a byte address.
// - Entry bits 0-12 supply the physical page number.
// - Absent bit 15 set raises page fault, no memory access.
// - Any access that translates without fault sets reference bit 13.
// - Any write that translates without fault sets dirty bit 14.
// - All maps share entry layout except maps 14 and 15.
// - Pages hold 2048 bytes; offsets pass through unchanged.
// - Store holds sixteen maps of sixty-four entries.
// - Data uses map 0; map 1 needs system-data or privilege.
`timescale 1ns/1ps
`default_nettype none
module logical_address_map_translation
    import addr_map_pkg::*;
(
    input  wire logic                      clk_sys,  // 10 MHz system clock
    input  wire logic                      rst,      // Synchronous, active high
    input  wire addr_map_pkg::xlate_req_t  req,      // Translation request
    output var  addr_map_pkg::xlate_resp_t resp,     // Translation result
    input  wire logic                      psel,     // APB select
    input  wire logic                      penable,  // APB enable
    input  wire logic                      pwrite,   // APB direction
    input  wire logic [15:0]               paddr,    // APB byte address
    input  wire logic [31:0]               pwdata,   // APB write data
    input  wire logic [3:0]                pstrb,    // APB byte strobes
    output logic [31:0]                    prdata,   // APB read data
    output logic                           pready,   // APB ready
    output logic                           pslverr   // APB error
);
    import addr_map_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [STORE_SIZE-1:0][ENTRY_W-1:0] store;
        logic [3:0]                         exec;
        logic [15:0]                        lastFault;
        xlate_resp_t                        resp;
        logic [31:0]                        prdata;
        logic                               pready;
        logic                               pslverr;
    } state_t;

    state_t st;
    state_t next_st;

    logic [3:0]        curMap;
    logic [5:0]        curPage;
    logic [WORD_W-1:0] curWord;
    logic              curByte;
    logic [9:0]        curIdx;
    logic [ENTRY_W-1:0] curEntry;
    logic              curPriv;
    logic              curMiss;
    logic              curOk;

    function automatic logic [9:0] entryIndex(input logic [3:0] map, input logic [5:0] page);
        return {map, page};
    endfunction

    function automatic logic [15:0] laneMerge(input logic [15:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
        return {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
    endfunction

    // ****************************************
    // Translation and register access
    // ****************************************
    always_comb begin
        logic ds;
        logic privileged_state_bit;
        logic [ENTRY_W-1:0] idEntry;
        logic [9:0] wIdx;
        ds      = st.exec[EXEC_DS_BIT];
        privileged_state_bit    = st.exec[EXEC_PRIVILEGED_STATE_BIT_BIT];
        idEntry = '0;
        wIdx    = paddr[11:2];
        next_st = st;
        curMap  = MAP_USER_DATA;
        curPage = '0;
        curWord = '0;
        curByte = 1'b0;
        curPriv = 1'b0;
        curMiss = 1'b0;

        // Address fields are numbered MSB first: field bit n is vector bit W-1-n
        case (req.kind)
            REQ_WORD: begin
                curPage = req.addr[15:10];
                curWord = req.addr[9:0];
            end
            REQ_BYTE_DATA: begin
                curPage = {1'b0, req.addr[15:11]};
                curWord = req.addr[10:1];
                curByte = req.addr[0];
            end
            REQ_BYTE_CODE: begin
                curPage = {req.pcPageHigh, req.addr[15:11]};
                curWord = req.addr[10:1];
                curByte = req.addr[0];
            end
            REQ_EXTENDED: begin
                // Bit 1 is assumed zero and not decoded
                curPage = req.addr[16:11];
                curWord = req.addr[10:1];
                curByte = req.addr[0];
            end
            default: curPage = '0;
        endcase

        if (req.kind == REQ_EXTENDED) begin
            // Only the map entry cache is searched; a miss goes back to microcode
            curMap  = MAP_EXT_CACHE;
            curPriv = req.addr[31] && !privileged_state_bit;
            idEntry = st.store[entryIndex(MAP_EXT_CACHE, {1'b1, curPage[4:0]})];
            curMiss = idEntry[ENTRY_W-1:ENT_PPN_LSB] != req.addr[29:17]
                   || idEntry[ENT_ID_PMSB] != curPage[5];
            curPage = {1'b0, curPage[4:0]};
        end else if (req.kind == REQ_BYTE_CODE) begin
            curMap = MAP_CODE_BASE + {2'b00, st.exec[EXEC_LS_BIT], st.exec[EXEC_CS_BIT]};
        end else if (ds || req.sysSpace) begin
            curMap  = MAP_SYS_DATA;
            curPriv = !(ds || privileged_state_bit);
        end

        curIdx   = entryIndex(curMap, curPage);
        curEntry = st.store[curIdx];
        curOk    = req.valid && !curPriv && !curMiss && !curEntry[ENT_ABSENT];

        // APB: answer in the access phase after one setup cycle
        if (psel && !penable && !st.pready) begin
            next_st.pready  = 1'b1;
            next_st.pslverr = 1'b0;
            next_st.prdata  = '0;
            if (paddr[15:12] == MAP_BASE[15:12])
                next_st.prdata = {16'h0000, st.store[wIdx]};
            else if (paddr == EXEC_OFFSET)
                next_st.prdata = {28'h0000000, st.exec};
            else if (paddr == STATUS_OFFSET)
                next_st.prdata = {16'h0000, st.lastFault};
            else
                next_st.pslverr = 1'b1;
        end else if (psel && penable && st.pready) begin
            next_st.pready  = 1'b0;
            next_st.pslverr = 1'b0;
            next_st.prdata  = '0;
            if (pwrite && paddr[15:12] == MAP_BASE[15:12])
                next_st.store[wIdx] = laneMerge(st.store[wIdx], pwdata, pstrb);
            else if (pwrite && paddr == EXEC_OFFSET && pstrb[0])
                next_st.exec = pwdata[3:0];
        end

        next_st.resp.valid     = req.valid;
        next_st.resp.pageFault = req.valid && !curPriv && !curMiss && curEntry[ENT_ABSENT];
        next_st.resp.privFault = req.valid && curPriv;
        next_st.resp.cacheMiss = req.valid && !curPriv && curMiss;
        next_st.resp.physAddr  = '0;
        if (curOk) begin
            // Offset within the 2048-byte page passes untranslated
            next_st.resp.physAddr = {curEntry[ENTRY_W-1:ENT_PPN_LSB], curWord, curByte};
            // Applied after any software write so hardware set wins
            next_st.store[curIdx][ENT_REF] = 1'b1;
            if (req.write)
                next_st.store[curIdx][ENT_DIRTY] = 1'b1;
        end
        if (req.valid && !curOk)
            next_st.lastFault = {2'b00, curMap, curPage, 1'b0, curMiss, curPriv, !curPriv && !curMiss};
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign resp    = st.resp;
    assign prdata  = st.prdata;
    assign pready  = st.pready;
    assign pslverr = st.pslverr;

    // ****************************************
    // Checks
    // ****************************************
    a_word_page_field: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid && req.kind == REQ_WORD |-> curPage == req.addr[15:10])
        else $error("word page field wrong");

    a_word_offset_pass: assert property (@(posedge clk_sys) disable iff (rst)
        curOk && req.kind == REQ_WORD |=> resp.physAddr[10:0] == {$past(req.addr[9:0]), 1'b0})
        else $error("word offset not carried");

    a_byte_select_bit: assert property (@(posedge clk_sys) disable iff (rst)
        curOk && req.kind == REQ_BYTE_DATA |=> resp.physAddr[0] == $past(req.addr[0]))
        else $error("byte select wrong");

    a_byte_low_half: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid && req.kind == REQ_BYTE_DATA |-> curPage[5] == 1'b0)
        else $error("data byte page beyond 32");

    a_code_pc_half: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid && req.kind == REQ_BYTE_CODE |-> curPage[5] == req.pcPageHigh)
        else $error("code byte half wrong");

    a_abs_needs_privileged_state_bit: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid && req.kind == REQ_EXTENDED && req.addr[31] && !st.exec[EXEC_PRIVILEGED_STATE_BIT_BIT]
        |=> resp.privFault && resp.physAddr == '0)
        else $error("absolute mode allowed unprivileged");

    a_ppn_supplied: assert property (@(posedge clk_sys) disable iff (rst)
        curOk |=> resp.physAddr[PHYS_W-1:WORD_W+1] == $past(curEntry[ENTRY_W-1:ENT_PPN_LSB]))
        else $error("physical page wrong");

    a_absent_faults: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid && !curPriv && !curMiss && curEntry[ENT_ABSENT]
        |=> resp.valid && resp.pageFault && resp.physAddr == '0)
        else $error("absent page not faulted");

    a_ref_bit_set: assert property (@(posedge clk_sys) disable iff (rst)
        curOk |=> st.store[$past(curIdx)][ENT_REF])
        else $error("reference bit not set");

    a_dirty_bit_set: assert property (@(posedge clk_sys) disable iff (rst)
        curOk && req.write |=> st.store[$past(curIdx)][ENT_DIRTY])
        else $error("dirty bit not set");

    a_data_map_zero: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid && req.kind == REQ_WORD && !req.sysSpace && !st.exec[EXEC_DS_BIT]
        |-> curMap == MAP_USER_DATA)
        else $error("user data not on map 0");

    // ****************************************
    // Field order, offset, extended, map selection and fault checks
    // ****************************************
    a_word_field_order: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid && req.kind == REQ_WORD |-> curWord == req.addr[9:0])
        else $error("word field order wrong");

    a_code_offset_pass: assert property (@(posedge clk_sys) disable iff (rst)
        curOk && req.kind == REQ_BYTE_CODE |=> resp.physAddr[WORD_W:0] == $past(req.addr[10:0]))
        else $error("code byte offset not carried");

    a_code_map_sel: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid && req.kind == REQ_BYTE_CODE
        |-> curMap == MAP_CODE_BASE + {2'b00, st.exec[EXEC_LS_BIT], st.exec[EXEC_CS_BIT]})
        else $error("code map select wrong");

    a_no_special_map: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid && req.kind != REQ_EXTENDED |-> curMap != MAP_SPECIAL && curMap != MAP_EXT_CACHE)
        else $error("standard access on special map");

    a_ext_cache_only: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid && req.kind == REQ_EXTENDED |-> curMap == MAP_EXT_CACHE && curIdx[5] == 1'b0)
        else $error("extended lookup outside cache half");

    a_ext_offset_pass: assert property (@(posedge clk_sys) disable iff (rst)
        curOk && req.kind == REQ_EXTENDED |=> resp.physAddr[WORD_W:0] == $past(req.addr[10:0]))
        else $error("extended offset not carried");

    a_ext_byte_addr: assert property (@(posedge clk_sys) disable iff (rst)
        curOk && req.kind == REQ_EXTENDED |=> resp.physAddr[0] == $past(req.addr[0]))
        else $error("extended byte select lost");

    a_seg_mismatch: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid && req.kind == REQ_EXTENDED && !curPriv
        && st.store[{MAP_EXT_CACHE, 1'b1, req.addr[15:11]}][ENTRY_W-1:ENT_PPN_LSB] != req.addr[29:17]
        |=> resp.cacheMiss && resp.physAddr == '0)
        else $error("segment mismatch not reported");

    a_abs_privileged_state_bit_ok: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid && req.kind == REQ_EXTENDED && st.exec[EXEC_PRIVILEGED_STATE_BIT_BIT] |=> !resp.privFault)
        else $error("privileged absolute access refused");

    a_sys_map_guard: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid && curMap == MAP_SYS_DATA && !st.exec[EXEC_DS_BIT] && !st.exec[EXEC_PRIVILEGED_STATE_BIT_BIT]
        |=> resp.privFault && resp.physAddr == '0)
        else $error("system map reached unprivileged");

    a_fault_no_touch: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid && !curOk && !(psel && penable && st.pready && pwrite)
        |=> st.store[$past(curIdx)] == $past(curEntry))
        else $error("faulted entry changed");

    a_fault_no_addr: assert property (@(posedge clk_sys) disable iff (rst)
        req.valid && !curOk |=> resp.valid && resp.physAddr == '0)
        else $error("faulted access gave an address");
endmodule // logical_address_map_translation
`default_nettype wire

// ===== verification/datapath_requester.sv
/*
  Requester model: the processor datapath side of the translation port.
  Assumes it shares clk_sys with the translator and sends one request per call.
*/
`timescale 1ns/1ps
`default_nettype none
module datapath_requester
    import addr_map_pkg::*;
(
    input  wire logic                      clk_sys, // System clock
    output var  addr_map_pkg::xlate_req_t  req,     // Request to translator
    input  wire addr_map_pkg::xlate_resp_t resp     // Translator answer
);
    initial req = '0;

    // Idle address lines are inverted so stale values never look valid
    task automatic issue(input xlate_req_t q, output xlate_resp_t r);
        if (q.kind == REQ_EXTENDED) begin
            q.addr[30] = 1'b0;
        end
        @(posedge clk_sys);
        req <= q;
        @(posedge clk_sys);
        req.valid <= 1'b0;
        req.addr  <= ~q.addr;
        @(posedge clk_sys);
        r = resp;
    endtask
endmodule // datapath_requester
`default_nettype wire

// ===== verification/logical_address_map_translation_test.sv
/*
  Self-checking bench for the address translator: APB master, requester model
  and one task per scenario. Assumes a single 10 MHz clock and sync reset.
*/
`timescale 1ns/1ps
`default_nettype none
module logical_address_map_translation_test;
    import addr_map_pkg::*;
    logic        clk_sys;
    logic        rst;
    xlate_req_t  req;
    xlate_resp_t resp;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    int          nFail, checksDone;

    logical_address_map_translation dut (.clk_sys(clk_sys), .rst(rst), .req(req), .resp(resp),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    datapath_requester model (.clk_sys(clk_sys), .req(req), .resp(resp));

    // ********************************
    // Helpers
    // ********************************
    task automatic stopTest;
        if (nFail == 0 && checksDone > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checksDone++;
        if (got !== exp) begin
            nFail++;
            $display("unexpected at %0t ns: %s", $time, m);
        end
    endtask

    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge clk_sys);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // A dead slave is caught by the watchdog
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic rchk(input logic [15:0] a, input logic [31:0] e, input string m);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0, rd, err);
        chk({err, rd[30:0]}, e, m);
    endtask

    function automatic logic [15:0] ea(input int m, input int e);
        return 16'(((m * 64) + e) * 4);
    endfunction

    // Flags are {pageFault, privFault, cacheMiss}
    task automatic xl(input req_kind_t k, input logic w, input logic s, input logic pc,
                      input logic [31:0] a, input logic [23:0] pa, input logic [2:0] fl, input string m);
        xlate_resp_t r;
        model.issue({1'b1, k, w, s, pc, a}, r);
        chk({4'h0, r}, {4'h0, 1'b1, pa, fl}, m);
    endtask

    // ********************************
    // Scenarios
    // ********************************
    task automatic t_regs;
        logic [31:0] rd;
        logic        err;
        rchk(ea(0, 1), 32'h0, "entry after reset");
        rchk(EXEC_OFFSET, 32'h0, "exec after reset");
        wr(ea(15, 63), 32'hFFFF_FFFF);
        rchk(ea(15, 63), 32'h0000_FFFF, "last entry width");
        apb(1'b0, 16'h2000, 32'h0, rd, err);
        chk({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
        pstrb <= 4'h1;
        wr(ea(0, 5), 32'h0000_ABCD);
        rchk(ea(0, 5), 32'h0000_00CD, "low lane only");
        pstrb <= 4'h2;
        wr(EXEC_OFFSET, 32'h1);
        rchk(EXEC_OFFSET, 32'h0, "exec needs lane 0");
        pstrb <= 4'hF;
    endtask

    task automatic t_word;
        wr(ea(0, 1), 32'h0918);
        xl(REQ_WORD, 1'b0, 1'b0, 1'b0, 32'h0405, {13'h123, 10'd5, 1'b0}, 3'h0, "word read");
        rchk(ea(0, 1), 32'h091C, "reference bit");
        xl(REQ_WORD, 1'b1, 1'b0, 1'b0, 32'h0405, {13'h123, 10'd5, 1'b0}, 3'h0, "word write");
        rchk(ea(0, 1), 32'h091E, "dirty bit");
        wr(ea(0, 2), 32'h0919);
        xl(REQ_WORD, 1'b1, 1'b0, 1'b0, 32'h0800, 24'h0, 3'h4, "absent page");
        rchk(ea(0, 2), 32'h0919, "entry kept on fault");
        rchk(STATUS_OFFSET, 32'h0000_0021, "fault status");
    endtask

    task automatic t_byte;
        wr(ea(0, 3), 32'h0A00);
        xl(REQ_BYTE_DATA, 1'b0, 1'b0, 1'b1, 32'h180F, {13'h140, 10'd7, 1'b1}, 3'h0, "data byte");
        wr(ea(2, 35), 32'h0B00);
        xl(REQ_BYTE_CODE, 1'b0, 1'b0, 1'b1, 32'h180E, {13'h160, 10'd7, 1'b0}, 3'h0, "code byte");
        wr(EXEC_OFFSET, 32'hC);
        wr(ea(5, 35), 32'h0E00);
        xl(REQ_BYTE_CODE, 1'b0, 1'b0, 1'b1, 32'h180E, {13'h1C0, 10'd7, 1'b0}, 3'h0, "lib code byte");
        wr(EXEC_OFFSET, 32'h0);
    endtask

    task automatic t_privileged_state_bit;
        wr(ea(1, 4), 32'h0C00);
        xl(REQ_WORD, 1'b0, 1'b1, 1'b0, 32'h1009, 24'h0, 3'h2, "system map refused");
        wr(EXEC_OFFSET, 32'h1);
        xl(REQ_WORD, 1'b0, 1'b0, 1'b0, 32'h1009, {13'h180, 10'd9, 1'b0}, 3'h0, "system map");
        wr(EXEC_OFFSET, 32'h0);
    endtask

    task automatic t_ext;
        logic [31:0] a;
        a = {1'b0, 1'b0, 13'h1ABC, 6'd37, 10'd9, 1'b1};
        wr(ea(15, 5), 32'h0D00);
        wr(ea(15, 37), 32'hD5E4);
        xl(REQ_EXTENDED, 1'b0, 1'b0, 1'b0, a, {13'h1A0, 10'd9, 1'b1}, 3'h0, "relative");
        xl(REQ_EXTENDED, 1'b0, 1'b0, 1'b0, a | 32'h8000_0000, 24'h0, 3'h2, "absolute user");
        xl(REQ_EXTENDED, 1'b0, 1'b0, 1'b0, a ^ 32'h0002_0000, 24'h0, 3'h1, "segment miss");
        wr(EXEC_OFFSET, 32'h2);
        xl(REQ_EXTENDED, 1'b0, 1'b0, 1'b0, a | 32'h8000_0000, {13'h1A0, 10'd9, 1'b1}, 3'h0, "absolute");
        wr(EXEC_OFFSET, 32'h0);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    initial begin
        nFail = 0;
        checksDone = 0;
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs;
        t_word;
        t_byte;
        t_privileged_state_bit;
        t_ext;
        stopTest;
    end

    // Whole run needs about 120 cycles
    initial begin
        #(100 * 3000);
        nFail++;
        stopTest;
    end
endmodule // logical_address_map_translation_test
`default_nettype wire
